//--- verilog/pcd_pkg.sv
// constants, field positions and source codes for the priority crossbar decoder
package pcd_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NPINS = 32;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int NSLOTS = 12;
   localparam int SRC_CNT = 17;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_ROUTE_FIRST = 8'hE1;
   localparam logic [7:0] IDX_ROUTE_THIRD = 8'hC7;
   localparam logic [7:0] IDX_SKIP = 8'h10;
   localparam logic [7:0] IDX_IN_MODE = 8'h11;
   localparam logic [7:0] IDX_OUT_MODE = 8'h12;
   localparam logic [7:0] IDX_LATCH = 8'h13;
   localparam logic [7:0] IDX_PIN_READ = 8'h14;
   localparam logic [7:0] IDX_SS_MODE = 8'h15;
   localparam logic [7:0] IDX_EV_SEL = 8'h16;
   localparam logic [7:0] IDX_EV_FLAG = 8'h17;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RF_CMP1_ASYNC = 7;
   localparam int RF_CMP1_SYNC = 6;
   localparam int RF_CMP0_ASYNC = 5;
   localparam int RF_CMP0_SYNC = 4;
   localparam int RF_SMBUS = 3;
   localparam int RF_SPI = 2;
   localparam int RF_CAN = 1;
   localparam int RF_UART = 0;
   localparam int RT_WEAK_PULLUP_DISABLE = 7;
   localparam int RT_CROSSBAR_ENABLE_BIT = 6;
   localparam int RT_LIN = 0;

   // ----------------------------------------------------------------
   // reset values, plus the three-wire select mode code
   // ----------------------------------------------------------------
   localparam logic [7:0] ROUTE_FIRST_RST = 8'h00;
   localparam logic [7:0] ROUTE_THIRD_RST = 8'h00;
   localparam logic SKIP_RST_BIT = 1'b0;
   localparam logic IN_MODE_RST_BIT = 1'b1;
   localparam logic OUT_MODE_RST_BIT = 1'b0;
   localparam logic LATCH_RST_BIT = 1'b1;
   localparam logic EV_SEL_RST_BIT = 1'b0;
   localparam logic [1:0] SS_MODE_RST = 2'h1;
   localparam logic [1:0] SS_MODE_3WIRE = 2'h0;

   // ----------------------------------------------------------------
   // fixed pins and source codes
   // ----------------------------------------------------------------
   localparam int PIN_UART_TX = 4;
   localparam int PIN_UART_RX = 5;
   localparam int PIN_CAN_TX = 6;
   localparam int PIN_CAN_RX = 7;

   typedef logic [4:0] pcd_src_type;
   localparam pcd_src_type SRC_GPIO = 5'h00;
   localparam pcd_src_type SRC_UART_TX = 5'h01;
   localparam pcd_src_type SRC_UART_RX = 5'h02;
   localparam pcd_src_type SRC_CAN_TX = 5'h03;
   localparam pcd_src_type SRC_CAN_RX = 5'h04;
   localparam pcd_src_type SRC_SLOT_BASE = 5'h05;
   // slots in priority order: sck miso mosi nss sda scl cp0 cp0a cp1 cp1a lin_tx lin_rx
   localparam pcd_src_type SRC_SDA = 5'h09;
   localparam pcd_src_type SRC_SCL = 5'h0A;
endpackage : pcd_pkg

//--- verilog/pcd_route_if.sv
// configuration in, pin sources out, between core and allocator
interface pcd_route_if #(parameter int NPINS = pcd_pkg::NPINS);
   logic [7:0] route_first;
   logic lin_en;
   logic [1:0] ss_mode;
   logic [NPINS-1:0] skip;
   pcd_pkg::pcd_src_type [NPINS-1:0] src;

   modport core (output route_first, output lin_en, output ss_mode, output skip, input src);
   modport alloc (input route_first, input lin_en, input ss_mode, input skip, output src);
endinterface : pcd_route_if

//--- verilog/pcd_allocator.sv
// combinational priority allocation of crossbar resources to pins
module pcd_allocator #(
   parameter int NPINS = pcd_pkg::NPINS
) (
   pcd_route_if.alloc rif
);
   import pcd_pkg::*;

   logic [NSLOTS-1:0] need;
   logic [NPINS-1:0] occ;
   logic found;
   pcd_src_type [NPINS-1:0] src;

   always_comb begin
      need = '0;
      need[0] = rif.route_first[RF_SPI];
      need[1] = rif.route_first[RF_SPI];
      need[2] = rif.route_first[RF_SPI];
      need[3] = rif.route_first[RF_SPI] & (rif.ss_mode != SS_MODE_3WIRE);
      need[4] = rif.route_first[RF_SMBUS];
      need[5] = rif.route_first[RF_SMBUS];
      need[6] = rif.route_first[RF_CMP0_SYNC];
      need[7] = rif.route_first[RF_CMP0_ASYNC];
      need[8] = rif.route_first[RF_CMP1_SYNC];
      need[9] = rif.route_first[RF_CMP1_ASYNC];
      need[10] = rif.lin_en;
      need[11] = rif.lin_en;
   end

   always_comb begin
      found = 1'b0;
      occ = rif.skip;
      for (int p = 0; p < NPINS; p++) begin
         src[p] = SRC_GPIO;
      end
      if (rif.route_first[RF_UART]) begin
         src[PIN_UART_TX] = SRC_UART_TX;
         src[PIN_UART_RX] = SRC_UART_RX;
         occ[PIN_UART_TX] = 1'b1;
         occ[PIN_UART_RX] = 1'b1;
      end
      if (rif.route_first[RF_CAN]) begin
         src[PIN_CAN_TX] = SRC_CAN_TX;
         src[PIN_CAN_RX] = SRC_CAN_RX;
         occ[PIN_CAN_TX] = 1'b1;
         occ[PIN_CAN_RX] = 1'b1;
      end
      // lowest free pin per slot, slots walked in priority order
      for (int s = 0; s < NSLOTS; s++) begin
         found = 1'b0;
         if (need[s]) begin
            for (int p = 0; p < NPINS; p++) begin
               if (!found && !occ[p]) begin
                  src[p] = SRC_SLOT_BASE + 5'(s);
                  occ[p] = 1'b1;
                  found = 1'b1;
               end
            end
         end
      end
   end

   assign rif.src = src;
endmodule : pcd_allocator

//--- verilog/pcd_pin_cell.sv
// one port cell: driver enable, open-drain handling and weak pull-up
module pcd_pin_cell (
   input wire logic dig,
   input wire logic push_pull,
   input wire logic xbar_en,
   input wire logic wpd,
   input wire logic is_smbus,
   input wire logic drv_req,
   input wire logic val,
   output logic out,
   output logic oe,
   output logic pull,
   output logic rx_en
);
   logic od;

   always_comb begin
      od = ~push_pull | is_smbus;
      out = val;
      oe = dig & xbar_en & drv_req & (~od | ~val);
      // the disable bit only reaches open-drain cells; push-pull keeps its pull
      pull = dig & (~wpd | ~od) & ~(oe & ~val);
      rx_en = dig;
   end
endmodule : pcd_pin_cell

//--- verilog/pcd_crossbar.sv
// priority crossbar decoder top: register slave, pin routing, event capture
// Function
// - lowest free unskipped pin, fixed priority order
// - uart tx on pin 4, rx pin 5
// - can tx on pin 6, rx pin 7
// - assigned pins passed over later
// - skipped pins never given to crossbar slots; uart and can pins ignore skip
// - paired lines requested together; each takes a pin only while a free one is left
// - leftover pins stay general-purpose port pins
// - spi takes three or four pins
// - crossbar off keeps every pin plain input
// - output drivers off while crossbar disabled
// - output mode bit picks driver type, except on smbus pins
// - smbus pins always open-drain
// - pull-ups on unless disable bit set on an open-drain pin
// - pull-up off while pin drives low
// - input mode 1 digital, 0 analog; reset digital
// - analog pin: no pull-up, driver, receiver
// - selected pin transition raises event/wake
// - events on any digital pin, never analog
// - first route register comparator enables, bits 7-4
// - first route register bits 3-0 peripheral enables
// - after reset pins floating with pull-ups
// - third register: enable bit 6, pull-up disable bit 7
//
// Implementation choice: the Avalon-MM register port.
module pcd_crossbar #(
   parameter int NPINS = pcd_pkg::NPINS
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [pcd_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pcd_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [pcd_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe,
   output logic [NPINS-1:0] pin_pull_en,
   output logic [NPINS-1:0] pin_rx_en,
   input wire logic [pcd_pkg::SRC_CNT-1:0] periph_out,
   input wire logic [pcd_pkg::SRC_CNT-1:0] periph_oe,
   output logic [pcd_pkg::SRC_CNT-1:0] periph_in,
   output logic [NPINS-1:0] event_flag,
   output logic event_wake
);
   import pcd_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic wait_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rd_mux;
   logic commit_wr;
   logic [7:0] idx;

   logic [7:0] route_first_r;
   logic weak_pullup_disable_r, crossbar_enable_bit_r, lin_en_r;
   logic [1:0] ss_mode_r;
   logic [NPINS-1:0] skip_r, in_mode_r, out_mode_r, latch_r, ev_sel_r;
   logic [NPINS-1:0] ev_flag_r;
   logic [NPINS-1:0] ev_flag_nxt;
   logic ev_wake_r;

   logic [NPINS-1:0] pin_meta_r, pin_sync_r, pin_prev_r;
   logic [NPINS-1:0] pin_read;
   logic [NPINS-1:0] ev_edge;

   pcd_src_type [NPINS-1:0] src_r;
   logic [NPINS-1:0] cell_val, cell_drv, cell_smb, cell_out, cell_oe, cell_pull, cell_rx;
   logic [NPINS-1:0] pin_out_r, pin_oe_r, pin_pull_r, pin_rx_r;
   logic [SRC_CNT-1:0] periph_in_r;
   logic [SRC_CNT-1:0] periph_in_nxt;

   // merge a write into a 32-bit image under byte enables
   function automatic logic [DATA_W-1:0] be_merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] wd,
      input logic [3:0] be
   );
      logic [DATA_W-1:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   // ----------------------------------------------------------------
   // pin input synchroniser
   // ----------------------------------------------------------------
   // pads are asynchronous to ref_clk; only pin_sync_r and its copy pin_prev_r are ever read
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         pin_prev_r <= '0;
      end else begin
         pin_meta_r <= pin_in;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // analog pins have no receiver and read back as zero
   assign pin_read = pin_sync_r & in_mode_r;

   // ----------------------------------------------------------------
   // avalon slave handshake
   // ----------------------------------------------------------------
   // one wait cycle per access; write and read data land on the low cycle
   assign idx = avs_address[ADDR_W-1:2];
   assign commit_wr = avs_write & ~wait_r;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wait_r <= 1'b1;
      end else if (wait_r && (avs_read || avs_write)) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdata_r <= '0;
      end else if (wait_r && avs_read) begin
         rdata_r <= rd_mux;
      end
   end

   always_comb begin
      rd_mux = '0;
      case (idx)
         IDX_ROUTE_FIRST: rd_mux = DATA_W'(route_first_r);
         IDX_ROUTE_THIRD: begin
            rd_mux[RT_WEAK_PULLUP_DISABLE] = weak_pullup_disable_r;
            rd_mux[RT_CROSSBAR_ENABLE_BIT] = crossbar_enable_bit_r;
            rd_mux[RT_LIN] = lin_en_r;
         end
         IDX_SKIP: rd_mux = DATA_W'(skip_r);
         IDX_IN_MODE: rd_mux = DATA_W'(in_mode_r);
         IDX_OUT_MODE: rd_mux = DATA_W'(out_mode_r);
         IDX_LATCH: rd_mux = DATA_W'(latch_r);
         IDX_PIN_READ: rd_mux = DATA_W'(pin_read);
         IDX_SS_MODE: rd_mux = DATA_W'(ss_mode_r);
         IDX_EV_SEL: rd_mux = DATA_W'(ev_sel_r);
         IDX_EV_FLAG: rd_mux = DATA_W'(ev_flag_r);
         default: rd_mux = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // routing enable registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         route_first_r <= ROUTE_FIRST_RST;
      end else if (commit_wr && idx == IDX_ROUTE_FIRST && avs_byteenable[0]) begin
         route_first_r <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         weak_pullup_disable_r <= ROUTE_THIRD_RST[RT_WEAK_PULLUP_DISABLE];
         crossbar_enable_bit_r <= ROUTE_THIRD_RST[RT_CROSSBAR_ENABLE_BIT];
         lin_en_r <= ROUTE_THIRD_RST[RT_LIN];
      end else if (commit_wr && idx == IDX_ROUTE_THIRD && avs_byteenable[0]) begin
         weak_pullup_disable_r <= avs_writedata[RT_WEAK_PULLUP_DISABLE];
         crossbar_enable_bit_r <= avs_writedata[RT_CROSSBAR_ENABLE_BIT];
         lin_en_r <= avs_writedata[RT_LIN];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ss_mode_r <= SS_MODE_RST;
      end else if (commit_wr && idx == IDX_SS_MODE && avs_byteenable[0]) begin
         ss_mode_r <= avs_writedata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // per-pin configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         skip_r <= {NPINS{SKIP_RST_BIT}};
      end else if (commit_wr && idx == IDX_SKIP) begin
         skip_r <= NPINS'(be_merge(DATA_W'(skip_r), avs_writedata, avs_byteenable));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         in_mode_r <= {NPINS{IN_MODE_RST_BIT}};
      end else if (commit_wr && idx == IDX_IN_MODE) begin
         in_mode_r <= NPINS'(be_merge(DATA_W'(in_mode_r), avs_writedata, avs_byteenable));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         out_mode_r <= {NPINS{OUT_MODE_RST_BIT}};
      end else if (commit_wr && idx == IDX_OUT_MODE) begin
         out_mode_r <= NPINS'(be_merge(DATA_W'(out_mode_r), avs_writedata, avs_byteenable));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         latch_r <= {NPINS{LATCH_RST_BIT}};
      end else if (commit_wr && idx == IDX_LATCH) begin
         latch_r <= NPINS'(be_merge(DATA_W'(latch_r), avs_writedata, avs_byteenable));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ev_sel_r <= {NPINS{EV_SEL_RST_BIT}};
      end else if (commit_wr && idx == IDX_EV_SEL) begin
         ev_sel_r <= NPINS'(be_merge(DATA_W'(ev_sel_r), avs_writedata, avs_byteenable));
      end
   end

   // ----------------------------------------------------------------
   // allocation
   // ----------------------------------------------------------------
   pcd_route_if #(.NPINS(NPINS)) rif ();

   assign rif.route_first = route_first_r;
   assign rif.lin_en = lin_en_r;
   assign rif.ss_mode = ss_mode_r;
   assign rif.skip = skip_r;

   pcd_allocator #(.NPINS(NPINS)) u_alloc (
      .rif(rif.alloc)
   );

   // the whole map is re-latched every cycle, so any write shows next edge
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         src_r <= '0;
      end else begin
         for (int p = 0; p < NPINS; p++) begin
            src_r[p] <= crossbar_enable_bit_r ? rif.src[p] : SRC_GPIO;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin cells
   // ----------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NPINS; p++) begin
         if (src_r[p] == SRC_GPIO) begin
            cell_val[p] = latch_r[p];
            cell_drv[p] = 1'b1;
         end else begin
            cell_val[p] = periph_out[src_r[p]];
            cell_drv[p] = periph_oe[src_r[p]];
         end
         cell_smb[p] = (src_r[p] == SRC_SDA) || (src_r[p] == SRC_SCL);
      end
   end

   for (genvar g = 0; g < NPINS; g++) begin : g_cell
      pcd_pin_cell u_cell (
         .dig(in_mode_r[g]),
         .push_pull(out_mode_r[g]),
         .xbar_en(crossbar_enable_bit_r),
         .wpd(weak_pullup_disable_r),
         .is_smbus(cell_smb[g]),
         .drv_req(cell_drv[g]),
         .val(cell_val[g]),
         .out(cell_out[g]),
         .oe(cell_oe[g]),
         .pull(cell_pull[g]),
         .rx_en(cell_rx[g])
      );
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pin_out_r <= '0;
         pin_oe_r <= '0;
         pin_pull_r <= '1;
         pin_rx_r <= '1;
      end else begin
         pin_out_r <= cell_out;
         pin_oe_r <= cell_oe;
         pin_pull_r <= cell_pull;
         pin_rx_r <= cell_rx;
      end
   end

   // ----------------------------------------------------------------
   // peripheral inputs
   // ----------------------------------------------------------------
   // unrouted inputs idle high, like a released serial line
   always_comb begin
      periph_in_nxt = '1;
      for (int c = 1; c < SRC_CNT; c++) begin
         for (int p = 0; p < NPINS; p++) begin
            if (src_r[p] == 5'(c)) begin
               periph_in_nxt[c] = pin_read[p];
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         periph_in_r <= '1;
      end else begin
         periph_in_r <= periph_in_nxt;
      end
   end

   // ----------------------------------------------------------------
   // event capture
   // ----------------------------------------------------------------
   // works on skipped and routed pins alike; analog pins are masked off
   assign ev_edge = (pin_sync_r ^ pin_prev_r) & in_mode_r & ev_sel_r;

   // write one to clear; a new edge in the clearing cycle still sets
   always_comb begin
      ev_flag_nxt = ev_flag_r;
      if (commit_wr && idx == IDX_EV_FLAG) begin
         ev_flag_nxt = ev_flag_r & ~NPINS'(be_merge('0, avs_writedata, avs_byteenable));
      end
      ev_flag_nxt = ev_flag_nxt | ev_edge;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ev_flag_r <= '0;
         ev_wake_r <= 1'b0;
      end else begin
         ev_flag_r <= ev_flag_nxt;
         ev_wake_r <= |ev_flag_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign pin_pull_en = pin_pull_r;
   assign pin_rx_en = pin_rx_r;
   assign periph_in = periph_in_r;
   assign event_flag = ev_flag_r;
   assign event_wake = ev_wake_r;
endmodule : pcd_crossbar

//--- bench/pcd_crossbar_sva.sv
// assertions on the crossbar decoder top ports
module pcd_crossbar_sva
   import pcd_pkg::*;
#(parameter int NPINS = 32) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [pcd_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pcd_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NPINS-1:0] pin_pull_en,
   input wire logic [NPINS-1:0] pin_rx_en,
   input wire logic [NPINS-1:0] event_flag,
   input wire logic event_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---
   // bus and pin relations
   // ---
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_answer: assert property (s_req |=> s_ack)
      else $error("bus answer late or long");
   a_no_early_ack: assert property (
      !avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   a_data_stands: assert property (
      !$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
      else $error("read data moved");
   a_reset_quiet: assert property (
      $rose(rstn) |-> pin_oe == '0 && (&pin_pull_en) && (&pin_rx_en))
      else $error("pins not quiet after reset");
   a_pull_drive_low: assert property ((pin_oe & ~pin_out & pin_pull_en) == '0)
      else $error("pull-up on while driving low");
   a_analog_dead: assert property ((~pin_rx_en & (pin_oe | pin_pull_en)) == '0)
      else $error("analog pin still active");
   a_wake_level: assert property (event_wake == (|event_flag))
      else $error("wake does not follow flags");
   // a flag may only drop after a committed write to the flag register
   a_flag_clear: assert property (
      $past(rstn) && (|($past(event_flag) & ~event_flag)) |->
      $past(avs_write && !avs_waitrequest && avs_address == {IDX_EV_FLAG, 2'h0}))
      else $error("event flag lost");
endmodule : pcd_crossbar_sva

bind pcd_crossbar pcd_crossbar_sva #(.NPINS(NPINS)) u_sva (.ref_clk, .rstn, .avs_address,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pin_out, .pin_oe,
   .pin_pull_en, .pin_rx_en, .event_flag, .event_wake);

//--- bench/pcd_board.sv
// board model: pad levels from device drive, pull-ups and external drivers
module pcd_board #(parameter int NPINS = 32) (
   input wire logic ref_clk,
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NPINS-1:0] pin_pull_en,
   input wire logic [NPINS-1:0] ext_en,
   input wire logic [NPINS-1:0] ext_val,
   output logic [NPINS-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---
   // pad resolution
   // ---
   logic flt_r = 1'b0;
   // an undriven pad with no pull wanders every cycle, so no stale level is read
   always @(posedge ref_clk) begin
      flt_r <= ~flt_r;
   end
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
      (~pin_oe & ~ext_en & (pin_pull_en | {NPINS{flt_r}}));
endmodule : pcd_board

//--- bench/testbench.sv
// self-checking bench for the priority crossbar decoder
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pcd_pkg::*;
   // ---
   // signals
   // ---
   localparam logic [9:0] A_RF = {IDX_ROUTE_FIRST, 2'h0};
   localparam logic [9:0] A_RT = {IDX_ROUTE_THIRD, 2'h0};
   localparam logic [9:0] A_SKIP = {IDX_SKIP, 2'h0};
   localparam logic [9:0] A_IN = {IDX_IN_MODE, 2'h0};
   localparam logic [9:0] A_OUT = {IDX_OUT_MODE, 2'h0};
   localparam logic [9:0] A_LAT = {IDX_LATCH, 2'h0};
   localparam logic [9:0] A_SS = {IDX_SS_MODE, 2'h0};
   localparam logic [9:0] A_EVS = {IDX_EV_SEL, 2'h0};
   localparam logic [9:0] A_EVF = {IDX_EV_FLAG, 2'h0};
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest, event_wake;
   logic [NPINS-1:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_rx_en, event_flag;
   logic [NPINS-1:0] ext_en = '0;
   logic [NPINS-1:0] ext_val = '0;
   logic [SRC_CNT-1:0] periph_out = '0;
   logic [SRC_CNT-1:0] periph_oe = '1;
   logic [SRC_CNT-1:0] periph_in;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   pcd_crossbar #(.NPINS(NPINS)) dut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out,
      .pin_oe, .pin_pull_en, .pin_rx_en, .periph_out, .periph_oe, .periph_in, .event_flag,
      .event_wake);
   pcd_board #(.NPINS(NPINS)) u_board (.ref_clk, .pin_out, .pin_oe, .pin_pull_en, .ext_en,
      .ext_val, .pin_in);
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // ---
   // tasks
   // ---
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : wr
   task rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      check(avs_readdata, exp);
   endtask : rd_chk
   task t_reset;
      check(pin_oe, '0);
      check(pin_pull_en, '1);
      rd_chk(A_RF, 32'h0);
      rd_chk(A_RT, 32'h0);
      rd_chk(A_IN, '1);
      rd_chk(10'h3FC, 32'h0);
      wr(A_RF, 32'hFF);
      rd_chk(A_RF, 32'hFF);
   endtask : t_reset
   task t_disabled;
      wr(A_OUT, '1);
      wr(A_LAT, '0);
      wr(A_SKIP, 32'h3);
      wr(A_RF, 32'h1F);
      tick(8);
      check(pin_oe, '0);
      check(32'(periph_in), 32'h1FFFF);
      check(pin_pull_en, '1);
   endtask : t_disabled
   task t_route(input logic [1:0] ss, input int pin_of[SRC_CNT]);
      logic [DATA_W-1:0] e, x;
      wr(A_SS, {30'h0, ss});
      wr(A_RT, 32'h41);
      for (int s = 1; s < SRC_CNT; s++) begin
         @(posedge ref_clk);
         periph_out <= SRC_CNT'(1) << s;
         tick(8);
         e = (pin_of[s] < 0) ? '0 : DATA_W'(1) << pin_of[s];
         x = 32'h1FFFE;
         for (int k = 1; k < SRC_CNT; k++) begin
            if (pin_of[k] >= 0) x[k] = (k == s);
         end
         check(pin_out, e);
         check(pin_oe, (s == SRC_SDA || s == SRC_SCL) ? ~e : '1);
         check(32'(periph_in) & ~32'h1, x);
      end
   endtask : t_route
   task t_event;
      wr(A_IN, ~(32'h1 << 21));
      wr(A_OUT, ~(32'h3 << 20));
      wr(A_LAT, 32'h7 << 20);
      tick(8);
      wr(A_EVS, 32'h3 << 20);
      tick(8);
      check(pin_rx_en & 32'h3 << 20, 32'h1 << 20);
      check(pin_pull_en & 32'h3 << 20, 32'h1 << 20);
      check(pin_oe & 32'h3 << 20, 32'h0);
      @(posedge ref_clk);
      ext_en <= 32'h3 << 20;
      tick(8);
      check(event_flag, 32'h1 << 20);
      check(32'(event_wake), 32'h1);
      wr(A_EVF, 32'h1 << 20);
      tick(2);
      check(event_flag, '0);
      wr(A_RT, 32'hC0);
      tick(8);
      // pin 22 is push-pull driving high, so it keeps its pull-up
      check(pin_pull_en & 32'h7 << 20, 32'h4 << 20);
   endtask : t_event
   // ---
   // main sequence
   // ---
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      tick(1);
      t_reset();
      t_disabled();
      t_route(2'h1, '{-1, 4, 5, 6, 7, 2, 3, 8, 9, 10, 11, 12, -1, -1, -1, 13, 14});
      // three-wire mode drops the select line, so everything below moves down one pin
      t_route(2'h0, '{-1, 4, 5, 6, 7, 2, 3, 8, -1, 9, 10, 11, -1, -1, -1, 12, 13});
      t_event();
      test_done();
   end
endmodule : testbench
